//--- design/kbl_pkg.sv
// Shared constants and types for the keyboard link controller
package kbl_pkg;
  localparam int unsigned KBL_NUM_CH = 3;
  localparam int unsigned KBL_DATA_W = 8;
  localparam int unsigned KBL_FIFO_DEPTH = 8;
  localparam int unsigned KBL_CLK_PERIOD_NS = 10;
  // Least time the clock line is held low before a transmit or release
  localparam int unsigned KBL_INHIBIT_US = 100;
  localparam int unsigned KBL_INHIBIT_CYC =
    (KBL_INHIBIT_US * 1000 + KBL_CLK_PERIOD_NS - 1) / KBL_CLK_PERIOD_NS;
  localparam int unsigned KBL_INHIBIT_CNT_W = 16;
  // Bit count at the falling edge that carries the stop bit (rx) / ack (tx)
  localparam logic [3:0] KBL_RX_LAST_BIT = 4'h9;
  localparam logic [3:0] KBL_TX_STOP_BIT = 4'hA;
  localparam logic [3:0] KBL_TX_ACK_BIT = 4'hB;
  localparam logic [3:0] KBL_CNT_RST = 4'h0;
  localparam logic [9:0] KBL_SHIFT_RST = 10'h000;
  localparam logic [1:0] KBL_SYNC_RST = 2'h3;

  typedef enum logic [2:0] {
    KBL_ST_IDLE,
    KBL_ST_RX,
    KBL_ST_INHIBIT,
    KBL_ST_TX
  } kbl_state_e;

  typedef struct packed {
    logic [KBL_DATA_W-1:0] data;
    logic parity_err;
    logic stop_err;
  } kbl_rx_word_s;

  typedef struct packed {
    logic done;
    logic acked;
  } kbl_tx_status_s;

  localparam int unsigned KBL_RX_WORD_W = $bits(kbl_rx_word_s);
endpackage : kbl_pkg

//--- design/kbl_ctrl.sv
// Three-channel keyboard serial link controller with per-channel receive FIFO
// Behaviour
// R1: Three separate channels, each with its own clock and data line.
// R2: During reception both lines are inputs only; nothing is driven.
// R3: Receive start, eight data bits LSB first, odd parity, one stop bit.
// R4: Each received bit is sampled while the keyboard clock is low.
// R5: During transmission keyboard clocks; device drives the data line.
// R6: Transmit start, eight data bits LSB first, odd parity, one stop bit.
// R7: Transmit data changes at clock fall, stable through the high phase.
// R8: Device can abort keyboard sending by holding the clock line low.
// R9: Keyboard abandons sending when it sees the clock held low.
// R10: Each channel pulses a completion flag when a whole frame is received.
// R11: Received frames are checked for odd parity and a correct stop bit.
// R12: Lines are driven straight from the block's own pin signals.
// R13: Lines are only driven low or released to the pull-up.
// R14: Leaving abort, data start bit is driven low, then clock released.
// R15: After the stop bit data is released and keyboard ack is recorded.
`timescale 1ns/1ps

module kbl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  // Pointers carry one extra bit so a full store differs from an empty one
  logic [AW:0] wr_q;
  logic [AW:0] wr_d;
  logic [AW:0] rd_q;
  logic [AW:0] rd_d;
  logic push;
  logic pop;

  always_comb begin
    in_ready_o = (wr_q - rd_q) != (AW+1)'(DEPTH);
    out_valid_o = wr_q != rd_q;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    mem_d = mem_q;
    if (push) begin
      mem_d[wr_q[AW-1:0]] = in_data_i;
    end
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    // Head word comes straight from storage, not from the write path
    out_data_o = mem_q[rd_q[AW-1:0]];
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      mem_q <= mem_d;
    end
  end
endmodule : kbl_fifo

module kbl_ctrl
  import kbl_pkg::*;
#(
  parameter int unsigned NUM_CH = kbl_pkg::KBL_NUM_CH,
  parameter int unsigned FIFO_DEPTH = kbl_pkg::KBL_FIFO_DEPTH,
  parameter int unsigned INHIBIT_CYC = kbl_pkg::KBL_INHIBIT_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [NUM_CH-1:0] kb_link_clock_i,
  output logic [NUM_CH-1:0] kb_link_clock_o,
  output logic [NUM_CH-1:0] kb_link_clock_oe_o,
  input wire logic [NUM_CH-1:0] kb_link_data_i,
  output logic [NUM_CH-1:0] kb_link_data_o,
  output logic [NUM_CH-1:0] kb_link_data_oe_o,
  input wire logic [NUM_CH-1:0] abort_i,
  input wire logic [NUM_CH-1:0] tx_valid_i,
  output logic [NUM_CH-1:0] tx_ready_o,
  input wire logic [NUM_CH-1:0][kbl_pkg::KBL_DATA_W-1:0] tx_data_i,
  output kbl_pkg::kbl_tx_status_s [NUM_CH-1:0] tx_status_o,
  output logic [NUM_CH-1:0] rx_done_o,
  output logic [NUM_CH-1:0] rx_valid_o,
  input wire logic [NUM_CH-1:0] rx_ready_i,
  output kbl_pkg::kbl_rx_word_s [NUM_CH-1:0] rx_word_o
);
  import kbl_pkg::*;

  localparam logic [KBL_INHIBIT_CNT_W-1:0] INHIBIT_LAST =
    KBL_INHIBIT_CNT_W'(INHIBIT_CYC - 1);

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch // R1
    logic [1:0] clk_sync_q;
    logic [1:0] clk_sync_d;
    logic [1:0] dat_sync_q;
    logic [1:0] dat_sync_d;
    logic clk_prev_q;
    logic clk_prev_d;
    kbl_state_e state_q;
    kbl_state_e state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [9:0] sh_q;
    logic [9:0] sh_d;
    logic [KBL_INHIBIT_CNT_W-1:0] inh_q;
    logic [KBL_INHIBIT_CNT_W-1:0] inh_d;
    logic clk_oe_q;
    logic clk_oe_d;
    logic dat_oe_q;
    logic dat_oe_d;
    logic rx_done_q;
    logic rx_done_d;
    kbl_tx_status_s txs_q;
    kbl_tx_status_s txs_d;
    kbl_rx_word_s word_q;
    kbl_rx_word_s word_d;
    logic push_q;
    logic push_d;
    logic fifo_ready;
    logic clk_fall;
    logic clk_s;
    logic dat_s;
    logic hold_req;

    // Two-stage synchronisers; only the second stage is read by logic
    assign clk_s = clk_sync_q[1];
    assign dat_s = dat_sync_q[1];
    assign clk_fall = clk_prev_q && !clk_s;
    // Back-pressure: a full FIFO holds the keyboard off before it starts
    assign hold_req = abort_i[ch] || !fifo_ready || tx_valid_i[ch];

    always_comb begin
      clk_sync_d = {clk_sync_q[0], kb_link_clock_i[ch]};
      dat_sync_d = {dat_sync_q[0], kb_link_data_i[ch]};
      clk_prev_d = clk_s;
      state_d = state_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      inh_d = inh_q;
      clk_oe_d = clk_oe_q;
      dat_oe_d = dat_oe_q;
      rx_done_d = 1'b0;
      txs_d = '0;
      txs_d.acked = txs_q.acked;
      word_d = word_q;
      push_d = push_q && !fifo_ready;
      tx_ready_o[ch] = 1'b0;
      case (state_q)
        KBL_ST_IDLE: begin
          clk_oe_d = 1'b0;
          dat_oe_d = 1'b0;
          cnt_d = KBL_CNT_RST;
          // Holding the keyboard off wins over a start arriving together, except while a push_q word is still pending
          if (hold_req && !push_q) begin
            state_d = KBL_ST_INHIBIT; // R8
            clk_oe_d = 1'b1; // R8
            inh_d = '0;
          end else if (clk_fall && !dat_s) begin
            state_d = KBL_ST_RX; // R3
          end
        end
        KBL_ST_RX: begin
          // Lines stay released for the whole received frame
          clk_oe_d = 1'b0; // R2
          dat_oe_d = 1'b0; // R2
          // Abort drops the partial frame; nothing is pushed
          if (abort_i[ch]) begin
            state_d = KBL_ST_INHIBIT; // R8
            clk_oe_d = 1'b1; // R8
            inh_d = '0;
          end else if (clk_fall) begin
            sh_d = {dat_s, sh_q[9:1]}; // R4
            cnt_d = cnt_q + 4'h1;
            // Tenth fall after the start carries the stop bit
            if (cnt_q == KBL_RX_LAST_BIT) begin
              word_d.data = sh_q[8:1]; // R3
              word_d.parity_err = !(^{sh_q[9:1]}); // R11
              word_d.stop_err = !dat_s; // R11
              push_d = 1'b1;
              rx_done_d = 1'b1; // R10
              state_d = KBL_ST_IDLE;
            end
          end
        end
        KBL_ST_INHIBIT: begin
          clk_oe_d = 1'b1; // R8
          if (inh_q != INHIBIT_LAST) begin
            inh_d = inh_q + 1'b1;
          end else if (dat_oe_q) begin
            // Start bit already on the line: hand the clock to the keyboard
            clk_oe_d = 1'b0; // R14
            state_d = KBL_ST_TX;
            cnt_d = KBL_CNT_RST;
          end else if (tx_valid_i[ch] && !abort_i[ch]) begin
            // The byte is taken only after the full inhibit time
            tx_ready_o[ch] = 1'b1;
            sh_d = {1'b1, ~^tx_data_i[ch], tx_data_i[ch]}; // R6
            dat_oe_d = 1'b1; // R14
          end else if (!hold_req) begin
            // Nothing pending any more: let the keyboard send again
            clk_oe_d = 1'b0;
            state_d = KBL_ST_IDLE;
          end
        end
        KBL_ST_TX: begin
          clk_oe_d = 1'b0; // R5
          if (abort_i[ch]) begin
            state_d = KBL_ST_INHIBIT;
            clk_oe_d = 1'b1; // R8
            dat_oe_d = 1'b0;
            inh_d = '0;
          end else if (clk_fall) begin
            cnt_d = cnt_q + 4'h1;
            // Fall after the released stop bit: keyboard answers on data
            if (cnt_q == KBL_TX_STOP_BIT) begin
              txs_d.done = 1'b1;
              txs_d.acked = !dat_s; // R15
              state_d = KBL_ST_IDLE;
            end else begin
              // New bit set at the fall holds through the next high phase
              dat_oe_d = !sh_q[0]; // R7 R13
              sh_d = {1'b1, sh_q[9:1]}; // R6
            end
          end
        end
        default: begin
          state_d = KBL_ST_IDLE;
          clk_oe_d = 1'b0;
          dat_oe_d = 1'b0;
        end
      endcase
    end

    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
        clk_sync_q <= KBL_SYNC_RST;
        dat_sync_q <= KBL_SYNC_RST;
        clk_prev_q <= 1'b1;
        state_q <= KBL_ST_IDLE;
        cnt_q <= KBL_CNT_RST;
        sh_q <= KBL_SHIFT_RST;
        inh_q <= '0;
        clk_oe_q <= 1'b0;
        dat_oe_q <= 1'b0;
        rx_done_q <= 1'b0;
        txs_q <= '0;
        word_q <= '0;
        push_q <= 1'b0;
      end else begin
        clk_sync_q <= clk_sync_d;
        dat_sync_q <= dat_sync_d;
        clk_prev_q <= clk_prev_d;
        state_q <= state_d;
        cnt_q <= cnt_d;
        sh_q <= sh_d;
        inh_q <= inh_d;
        clk_oe_q <= clk_oe_d;
        dat_oe_q <= dat_oe_d;
        rx_done_q <= rx_done_d;
        txs_q <= txs_d;
        word_q <= word_d;
        push_q <= push_d;
      end
    end

    kbl_fifo #(
      .WIDTH(KBL_RX_WORD_W),
      .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(push_q),
      .in_ready_o(fifo_ready),
      .in_data_i(word_q),
      .out_valid_o(rx_valid_o[ch]),
      .out_ready_i(rx_ready_i[ch]),
      .out_data_o(rx_word_o[ch])
    );

    // Pins only pull low; a released line floats up on the pull-up
    assign kb_link_clock_o[ch] = 1'b0; // R13
    assign kb_link_data_o[ch] = 1'b0; // R13
    assign kb_link_clock_oe_o[ch] = clk_oe_q; // R12
    assign kb_link_data_oe_o[ch] = dat_oe_q; // R12
    assign rx_done_o[ch] = rx_done_q;
    assign tx_status_o[ch] = txs_q;
  end
endmodule : kbl_ctrl

//--- bench/kbl_kbd_model.sv
// Keyboard model for one link channel; it makes the link clock itself
`timescale 1ns/1ps
module kbl_kbd_model (
  input wire logic clk_line_i,
  input wire logic dat_line_i,
  output logic clk_pull_o,
  output logic dat_pull_o
);
  logic busy = 0;
  logic [8:0] got = '0;
  initial begin
    clk_pull_o = 0;
    dat_pull_o = 0;
  end
  // Low phase then part of the high phase; lines are only pulled low
  task automatic tick();
    clk_pull_o = 1;
    #62;
    clk_pull_o = 0;
    #31;
  endtask : tick
  task automatic send(input logic [7:0] b, input logic [1:0] bad);
    logic [10:0] f;
    f = {~bad[1], ~^b ^ bad[0], b, 1'b0};
    busy = 1;
    for (int i = 0; i < 11; i++) begin
      dat_pull_o = ~f[i];
      #32;
      if (!clk_line_i) break;
      tick();
    end
    dat_pull_o = 0;
    busy = 0;
  endtask : send
  // Host frame starts when the clock is released with data held low
  always @(posedge clk_line_i) begin
    if (!busy && !dat_line_i && $time > 300) begin
      for (int i = 0; i < 11; i++) begin
        #32;
        tick();
        if (i < 9) got[i] = dat_line_i;
        dat_pull_o = (i == 9);
      end
    end
  end
endmodule : kbl_kbd_model

//--- bench/kbl_ctrl_chk.sv
// Port assertions for the keyboard link controller
`timescale 1ns/1ps
module kbl_ctrl_chk
  import kbl_pkg::*;
#(
  parameter int unsigned NUM_CH = kbl_pkg::KBL_NUM_CH,
  parameter int unsigned INHIBIT_CYC = kbl_pkg::KBL_INHIBIT_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [NUM_CH-1:0] kb_link_clock_i,
  input wire logic [NUM_CH-1:0] kb_link_clock_o,
  input wire logic [NUM_CH-1:0] kb_link_clock_oe_o,
  input wire logic [NUM_CH-1:0] kb_link_data_o,
  input wire logic [NUM_CH-1:0] kb_link_data_oe_o,
  input wire logic [NUM_CH-1:0] abort_i,
  input wire logic [NUM_CH-1:0] tx_ready_o,
  input wire kbl_pkg::kbl_tx_status_s [NUM_CH-1:0] tx_status_o,
  input wire logic [NUM_CH-1:0] rx_done_o,
  input wire logic [NUM_CH-1:0] rx_valid_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence start_then_release;
    kb_link_data_oe_o[0] ##1 !kb_link_clock_oe_o[0];
  endsequence
  drive_low_a: assert property (kb_link_clock_o == '0 && kb_link_data_o == '0)
    else $error("line driven high");
  rx_quiet_a: assert property (rx_done_o != '0 |-> (rx_done_o & kb_link_data_oe_o) == '0)
    else $error("data driven in rx");
  rx_push_a: assert property (rx_done_o[0] |-> ##[1:3] rx_valid_o[0])
    else $error("rx word not stored");
  abort_hold_a: assert property (abort_i[1] [*3] |-> kb_link_clock_oe_o[1])
    else $error("abort not held");
  inhibit_len_a: assert property (
    tx_ready_o[0] |-> $past(kb_link_clock_oe_o[0], INHIBIT_CYC - 1))
    else $error("inhibit too short");
  start_seq_a: assert property (tx_ready_o[0] |=> start_then_release)
    else $error("bad start order");
  data_phase_a: assert property (
    $changed(kb_link_data_oe_o[0]) |-> !kb_link_clock_i[0] || $past(tx_ready_o[0]))
    else $error("data moved in high");
  tx_done_a: assert property (
    tx_status_o[0].done |-> !kb_link_data_oe_o[0] && !$past(kb_link_data_oe_o[0]))
    else $error("data kept after stop");
endmodule : kbl_ctrl_chk
bind kbl_ctrl kbl_ctrl_chk #(.NUM_CH(NUM_CH), .INHIBIT_CYC(INHIBIT_CYC)) u_chk (
  .clk_sys_i, .sys_rst_i, .kb_link_clock_i, .kb_link_clock_o, .kb_link_clock_oe_o,
  .kb_link_data_o, .kb_link_data_oe_o, .abort_i, .tx_ready_o, .tx_status_o, .rx_done_o,
  .rx_valid_o);

//--- bench/test_kbl_ctrl.sv
// Self-checking bench: three keyboard models, frames in both directions
`timescale 1ns/1ps
module test_kbl_ctrl;
  import kbl_pkg::*;
  logic clk_sys_i = 0;
  logic sys_rst_i = 1;
  logic hold = 0;
  logic [2:0] abort_i = 0;
  logic [2:0] tx_valid_i = 0;
  logic [2:0] rx_ready_i = 0;
  logic [2:0] tx_ready_o, rx_valid_o, coe, doe, rxd;
  int nexp[3] = '{0, 0, 0};
  int ndone[3] = '{0, 0, 0};
  logic [2:0][7:0] tx_data_i = '0;
  kbl_tx_status_s [2:0] st;
  kbl_rx_word_s [2:0] rw;
  wire [2:0] kc, kd;
  wire [2:0] cl = ~(coe | kc);
  wire [2:0] dl = ~(doe | kd);
  logic [31:0] s = 32'h0001_7AF6;
  logic [9:0] rq[3][$];
  logic [9:0] tq[$];
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  kbl_ctrl #(.INHIBIT_CYC(20)) dut (.clk_sys_i, .sys_rst_i, .kb_link_clock_i(cl),
    .kb_link_clock_o(), .kb_link_clock_oe_o(coe), .kb_link_data_i(dl), .kb_link_data_o(),
    .kb_link_data_oe_o(doe), .abort_i, .tx_valid_i, .tx_ready_o, .tx_data_i, .tx_status_o(st),
    .rx_done_o(rxd), .rx_valid_o, .rx_ready_i, .rx_word_o(rw));
  kbl_kbd_model m0 (.clk_line_i(cl[0]), .dat_line_i(dl[0]),
    .clk_pull_o(kc[0]), .dat_pull_o(kd[0]));
  kbl_kbd_model m1 (.clk_line_i(cl[1]), .dat_line_i(dl[1]),
    .clk_pull_o(kc[1]), .dat_pull_o(kd[1]));
  kbl_kbd_model m2 (.clk_line_i(cl[2]), .dat_line_i(dl[2]),
    .clk_pull_o(kc[2]), .dat_pull_o(kd[2]));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(input logic [9:0] a, input logic [9:0] e);
    comparisons++;
    if (a !== e) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, a, e);
    end
  endtask : chk
  task automatic results();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic rxn(input int c, input int n, input logic [1:0] bad);
    logic [7:0] b;
    repeat (n) begin
      b = s[10:3] ^ 8'(c);
      rq[c].push_back({b, bad[0], bad[1]});
      nexp[c]++;
      case (c)
        0: m0.send(b, bad);
        1: m1.send(b, bad);
        default: m2.send(b, bad);
      endcase
      #700;
    end
  endtask : rxn
  task automatic tx(input logic [7:0] b);
    @(negedge clk_sys_i);
    tq.push_back({1'b1, ~^b, b});
    tx_data_i[0] = b;
    tx_valid_i[0] = 1;
    for (int i = 0; i < 99 && tx_ready_o[0] !== 1'b1; i++) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    tx_valid_i[0] = 0;
    #2500;
  endtask : tx
  // Random drain stalls; the FIFO of channel 2 is frozen while hold is set
  always @(negedge clk_sys_i) begin
    s = lfsr(s);
    rx_ready_i = s[2:0] & {~hold, 2'b11};
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      results();
    end
  end
  always @(posedge clk_sys_i) begin
    for (int c = 0; c < 3; c++) begin
      if (rx_valid_o[c] && rx_ready_i[c]) chk(rw[c], rq[c].pop_front());
      if (rxd[c] === 1'b1) ndone[c]++;
    end
    if (st[0].done) chk({st[0].acked, m0.got}, tq.pop_front());
  end
  initial begin
    repeat (20) @(negedge clk_sys_i);
    sys_rst_i = 0;
    repeat (5) @(negedge clk_sys_i);
    fork
      rxn(0, 3, 2'b00);
      rxn(1, 3, 2'b00);
      rxn(2, 3, 2'b00);
    join
    rxn(1, 1, 2'b01);
    rxn(1, 1, 2'b10);
    @(posedge clk_sys_i) hold = 1;
    rxn(2, 8, 2'b00);
    chk({9'h0, coe[2]}, 10'h001);
    @(posedge clk_sys_i) hold = 0;
    for (int i = 0; i < 4; i++) tx(s[7:0] ^ 8'(i));
    @(negedge clk_sys_i);
    fork
      m1.send(8'h3C, 2'b00);
      begin
        #800;
        abort_i[1] = 1;
        #400;
        chk({9'h0, coe[1]}, 10'h001);
        #2000;
        abort_i[1] = 0;
      end
    join
    #3000;
    for (int c = 0; c < 3; c++) begin
      chk(10'(ndone[c]), 10'(nexp[c]));
      chk(10'(rq[c].size()), 10'h000);
    end
    chk(10'(tq.size()), 10'h000);
    results();
  end
endmodule : test_kbl_ctrl
